// File: hdl/ddr3_fe_map.svh
`ifndef DDR3_FE_MAP_SVH
`define DDR3_FE_MAP_SVH
// Array geometry
`define FE_BANKS 8
`define FE_BA_W 3
`define FE_ROW_W 15
`define FE_DQ_W 16
`define FE_MEM_IDX_W 7
// Address bus fields during commands
`define FE_AP_BIT 10
`define FE_BC_BIT 12
`define FE_MR0_DLL_RESET_BIT 8
// Command codes {ras_n, cas_n, we_n}, chip select low
`define FE_CMD_MRS 3'h0
`define FE_CMD_REF 3'h1
`define FE_CMD_PRE 3'h2
`define FE_CMD_ACT 3'h3
`define FE_CMD_WR 3'h4
`define FE_CMD_RD 3'h5
`define FE_CMD_ZQ 3'h6
`define FE_CMD_NOP 3'h7
// Core clocks per burst
`define FE_BL8_CLKS 3'h4
`define FE_BC4_CLKS 3'h2
// Controller register offsets
`define FE_REG_CMD 8'h04
`define FE_REG_ADDR 8'h08
`define FE_REG_MASK 8'h0C
`define FE_REG_DATA 8'h10
`define FE_REG_STATUS 8'h20
// Command and address register fields
`define FE_OP_ACT 3'h0
`define FE_OP_RD 3'h1
`define FE_OP_WR 3'h2
`define FE_OP_PRE 3'h3
`define FE_OP_ZQL 3'h4
`define FE_OP_ZQS 3'h5
`define FE_CMD_AP 3
`define FE_CMD_CHOP 4
`define FE_ADDR_BA_LSB 16
// Status register fields
`define FE_ST_BUSY 0
`define FE_ST_INIT 1
`define FE_ST_REFUSED 2
`define FE_ST_BANKS_LSB 8
// Initialization counts in REF_CLK cycles
`define FE_CKE_LOW_CLKS 16'h0010
`define FE_WAKE_CLKS 16'h0008
`define FE_MRD_CLKS 16'h0004
`define FE_ZQINIT_CLKS 16'h0020
`endif

// File: hdl/ddr3_fe_pkg.sv
`include "ddr3_fe_map.svh"
package ddr3_fe_pkg;
  typedef enum logic [2:0] {
    ST_CKE_LOW, ST_WAKE, ST_MRS, ST_GAP, ST_ZQ_WAIT, ST_READY, ST_BURST
  } ctl_state_e;
  typedef logic [`FE_DQ_W-1:0] beat_t;
endpackage : ddr3_fe_pkg

// File: hdl/ddr3_fe_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_fe_map.svh"
interface ddr3_fe_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`FE_BA_W-1:0] ba;
  logic [`FE_ROW_W-1:0] addr;
  // Two beats per clock: bit 0 even beat, bit 1 odd beat
  logic [1:0] lower_byte_write_mask;
  logic [1:0] upper_byte_write_mask;
  logic [2*`FE_DQ_W-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [2*`FE_DQ_W-1:0] dq_dev;
  logic dq_dev_oe;
  wire [2*`FE_DQ_W-1:0] dq;
  assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);
  modport mem (
    input cke, cs_n, ras_n, cas_n, we_n, ba, addr,
    input lower_byte_write_mask, upper_byte_write_mask, dq,
    output dq_dev, dq_dev_oe
  );
  modport ctl (
    output cke, cs_n, ras_n, cas_n, we_n, ba, addr,
    output lower_byte_write_mask, upper_byte_write_mask,
    output dq_ctl, dq_ctl_oe,
    input dq
  );
endinterface : ddr3_fe_if
`default_nettype wire

// File: hdl/ddr3_fe_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_fe_map.svh"

// Operation
// - Calibration only idle, clock enable twice high
// - Check clock enable now and one cycle before
// - Eight banks, each with own open row
// - Eight half-clock beats over four core clocks
// - Bursts of eight or chopped four, ordered
// - Controller activates a bank before column access
// - Activate captures bank and fifteen row bits
// - Column, auto-precharge bit, on-the-fly chop bit
// - Only idle commands between mode sets, calibration
// - Controller finishes initialization before normal access
// - Lower and upper write masks act independently
module ddr3_fe_device #(
  parameter int NBANK = `FE_BANKS,
  parameter int ROW_W = `FE_ROW_W
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  ddr3_fe_if.mem BUS,
  input wire logic OTF_ENABLE,
  input wire logic FIXED_CHOP,
  input wire logic INTERLEAVE,
  output logic ZQ_LONG,
  output logic ZQ_SHORT,
  output logic CMD_REFUSED,
  output logic [NBANK-1:0] BANK_OPEN
);

  localparam int DQ_W = `FE_DQ_W;
  localparam int MEM_W = `FE_MEM_IDX_W;

  function automatic logic [2:0] burst_col(
    input logic [2:0] start,
    input logic [2:0] beat,
    input logic ilv,
    input logic chp
  );
    logic [2:0] seq;
    seq = start + beat;
    if (ilv) begin
      burst_col = start ^ beat;
    end else if (chp) begin
      burst_col = {start[2], seq[1:0]};
    end else begin
      burst_col = seq;
    end
  endfunction : burst_col

  logic cke_prev;
  logic [NBANK-1:0] open;
  logic [ROW_W-1:0] row [NBANK];
  logic busy;
  logic dir_wr;
  logic chop;
  logic ap;
  logic [`FE_BA_W-1:0] bank_b;
  logic [2:0] start;
  logic [1:0] clk_idx;
  ddr3_fe_pkg::beat_t mem [2**MEM_W];

  // A command counts only with clock enable high now and before
  wire cmd_ok = BUS.cke & cke_prev & ~BUS.cs_n;
  wire [2:0] code = {BUS.ras_n, BUS.cas_n, BUS.we_n};
  wire is_act = cmd_ok & (code == `FE_CMD_ACT);
  wire is_rd = cmd_ok & (code == `FE_CMD_RD);
  wire is_wr = cmd_ok & (code == `FE_CMD_WR);
  wire is_pre = cmd_ok & (code == `FE_CMD_PRE);
  wire is_zq = cmd_ok & (code == `FE_CMD_ZQ);
  wire sel_open = open[BUS.ba];
  wire act_ok = is_act & ~sel_open;
  // Column commands during a burst are dropped, not queued
  wire col_ok = (is_rd | is_wr) & sel_open & ~busy;
  wire zq_ok = is_zq & ~(|open) & ~busy;
  wire refused = (is_act & sel_open) | ((is_rd | is_wr) & ~col_ok)
               | (is_zq & ~zq_ok);
  // Low address bit twelve asks for the chopped burst
  wire chop_sel = OTF_ENABLE ? ~BUS.addr[`FE_BC_BIT] : FIXED_CHOP;
  wire [1:0] last_idx = chop ? 2'h1 : 2'h3;
  wire burst_end = busy & (clk_idx == last_idx);
  wire [2:0] col0 = burst_col(start, {clk_idx, 1'b0}, INTERLEAVE, chop);
  wire [2:0] col1 = burst_col(start, {clk_idx, 1'b1}, INTERLEAVE, chop);
  // Storage keeps only row bit 0: other rows alias onto it
  wire row_lsb = row[bank_b][0];
  wire [MEM_W-1:0] idx0 = {bank_b, row_lsb, col0};
  wire [MEM_W-1:0] idx1 = {bank_b, row_lsb, col1};
  wire rd_beat = busy & ~dir_wr;
  wire [2*DQ_W-1:0] rd_word = rd_beat ? {mem[idx1], mem[idx0]} : '0;

  assign BANK_OPEN = open;

  // Precharge with the auto-precharge bit set closes every bank
  for (genvar g = 0; g < NBANK; g++) begin : g_bank
    wire hit = (BUS.ba == 3'(g));
    wire close = (is_pre & (BUS.addr[`FE_AP_BIT] | hit))
               | (burst_end & ap & (bank_b == 3'(g)));
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        open[g] <= 1'b0;
        row[g] <= '0;
      end else if (act_ok & hit) begin
        open[g] <= 1'b1;
        row[g] <= BUS.addr;
      end else if (close) begin
        open[g] <= 1'b0;
      end
    end
  end

  // Burst descriptor, latched once per accepted column command
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dir_wr <= 1'b0;
      chop <= 1'b0;
      ap <= 1'b0;
      bank_b <= '0;
      start <= '0;
    end else if (col_ok) begin
      dir_wr <= is_wr;
      chop <= chop_sel;
      ap <= BUS.addr[`FE_AP_BIT];
      bank_b <= BUS.ba;
      start <= BUS.addr[2:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      busy <= 1'b0;
      clk_idx <= 2'h0;
    end else if (col_ok) begin
      busy <= 1'b1;
      clk_idx <= 2'h0;
    end else if (busy) begin
      clk_idx <= clk_idx + 2'h1;
      if (burst_end) begin
        busy <= 1'b0;
      end
    end
  end

  // Two beats land per clock; each byte lane has its own mask
  always_ff @(posedge REF_CLK) begin
    if (busy & dir_wr) begin
      if (!BUS.lower_byte_write_mask[0]) begin
        mem[idx0][7:0] <= BUS.dq[7:0];
      end
      if (!BUS.upper_byte_write_mask[0]) begin
        mem[idx0][15:8] <= BUS.dq[15:8];
      end
      if (!BUS.lower_byte_write_mask[1]) begin
        mem[idx1][7:0] <= BUS.dq[23:16];
      end
      if (!BUS.upper_byte_write_mask[1]) begin
        mem[idx1][15:8] <= BUS.dq[31:24];
      end
    end
  end

  // Registered, so read data leave one clock after the core beat
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BUS.dq_dev <= '0;
    end else begin
      BUS.dq_dev <= rd_word;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BUS.dq_dev_oe <= 1'b0;
    end else begin
      BUS.dq_dev_oe <= rd_beat;
    end
  end

  // Previous clock enable, needed by every command decode
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= BUS.cke;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ZQ_LONG <= 1'b0;
      ZQ_SHORT <= 1'b0;
    end else begin
      ZQ_LONG <= zq_ok & BUS.addr[`FE_AP_BIT];
      ZQ_SHORT <= zq_ok & ~BUS.addr[`FE_AP_BIT];
    end
  end

  // A pulse only: the controller keeps the sticky status
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_REFUSED <= 1'b0;
    end else begin
      CMD_REFUSED <= refused;
    end
  end

endmodule : ddr3_fe_device
`default_nettype wire

// File: hdl/ddr3_fe_controller.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_fe_map.svh"

module ddr3_fe_controller #(
  parameter logic [15:0] CKE_LOW_CLKS = `FE_CKE_LOW_CLKS,
  parameter logic [15:0] WAKE_CLKS = `FE_WAKE_CLKS,
  parameter logic [15:0] MRD_CLKS = `FE_MRD_CLKS,
  parameter logic [15:0] ZQINIT_CLKS = `FE_ZQINIT_CLKS
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  ddr3_fe_if.ctl BUS,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);

  ddr3_fe_pkg::ctl_state_e state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [1:0] mrs_idx, next_idx;
  logic next_cke, next_cs_n;
  logic [2:0] next_code;
  logic [`FE_BA_W-1:0] next_ba;
  logic [`FE_ROW_W-1:0] next_a;
  logic [31:0] addr_reg;
  logic [15:0] mask_reg;
  logic [31:0] data [4];
  logic [`FE_BANKS-1:0] shadow;
  logic init_done, refused;
  logic bdir, bchop, bap;
  logic [`FE_BA_W-1:0] bbank;

  wire [2:0] op = WDATA[2:0];
  wire cmd_ap = WDATA[`FE_CMD_AP];
  wire cmd_chop = WDATA[`FE_CMD_CHOP];
  wire [`FE_BA_W-1:0] sel_ba = addr_reg[`FE_ADDR_BA_LSB +: `FE_BA_W];
  wire bank_is_open = shadow[sel_ba];
  wire is_col = (op == `FE_OP_RD) | (op == `FE_OP_WR);
  wire is_zq = (op == `FE_OP_ZQL) | (op == `FE_OP_ZQS);
  wire legal = ((op == `FE_OP_ACT) & ~bank_is_open)
             | (is_col & bank_is_open)
             | (op == `FE_OP_PRE)
             | (is_zq & ~(|shadow));
  wire cmd_wr = WR & (ADDR == `FE_REG_CMD);
  // No software command reaches the pins before initialization ends
  wire launch = cmd_wr & (state == ddr3_fe_pkg::ST_READY) & legal;
  wire refuse = cmd_wr & ~launch;
  wire [2:0] n_clks = bchop ? `FE_BC4_CLKS : `FE_BL8_CLKS;
  wire [2:0] last3 = bdir ? n_clks : n_clks + 3'h1;
  wire in_burst = (state == ddr3_fe_pkg::ST_BURST);
  wire [2:0] bc = cnt[2:0];
  wire drive = in_burst & bdir & (bc < n_clks);
  wire capture = in_burst & ~bdir & (bc >= 3'h2) & (bc <= last3);
  wire [1:0] cap_idx = 2'(bc - 3'h2);
  wire burst_done = in_burst & (cnt == {13'h0000, last3});
  wire is_data = (ADDR[7:4] == 4'h1);
  wire [31:0] status_w = {16'h0000, shadow, 5'h00, refused, init_done,
                          ~(state == ddr3_fe_pkg::ST_READY)};
  wire [31:0] rd_mux = (ADDR == `FE_REG_STATUS) ? status_w
                     : (ADDR == `FE_REG_ADDR) ? addr_reg
                     : (ADDR == `FE_REG_MASK) ? {16'h0000, mask_reg}
                     : is_data ? data[ADDR[3:2]] : 32'h0000_0000;
  wire [`FE_BA_W-1:0] mrs_ba = (mrs_idx == 2'h0) ? 3'h2
                             : (mrs_idx == 2'h1) ? 3'h3
                             : (mrs_idx == 2'h2) ? 3'h1 : 3'h0;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 16'h0001;
    next_idx = mrs_idx;
    next_cke = BUS.cke;
    next_cs_n = 1'b0;
    next_code = `FE_CMD_NOP;
    next_ba = '0;
    next_a = '0;
    case (state)
      ddr3_fe_pkg::ST_CKE_LOW: begin
        next_cke = 1'b0;
        next_cs_n = 1'b1;
        if (cnt == CKE_LOW_CLKS) begin
          next_state = ddr3_fe_pkg::ST_WAKE;
          next_cnt = '0;
        end
      end
      ddr3_fe_pkg::ST_WAKE: begin
        next_cke = 1'b1;
        if (cnt == WAKE_CLKS) begin
          next_state = ddr3_fe_pkg::ST_MRS;
          next_cnt = '0;
        end
      end
      ddr3_fe_pkg::ST_MRS: begin
        next_code = `FE_CMD_MRS;
        next_ba = mrs_ba;
        next_a[`FE_MR0_DLL_RESET_BIT] = (mrs_idx == 2'h3);
        next_state = ddr3_fe_pkg::ST_GAP;
        next_cnt = '0;
      end
      ddr3_fe_pkg::ST_GAP: begin
        // Idle commands fill each gap up to the next mode set or, after the last one, the long calibration
        if (cnt == MRD_CLKS) begin
          next_cnt = '0;
          if (mrs_idx == 2'h3) begin
            next_code = `FE_CMD_ZQ;
            next_a[`FE_AP_BIT] = 1'b1;
            next_state = ddr3_fe_pkg::ST_ZQ_WAIT;
          end else begin
            next_idx = mrs_idx + 2'h1;
            next_state = ddr3_fe_pkg::ST_MRS;
          end
        end
      end
      ddr3_fe_pkg::ST_ZQ_WAIT: begin
        if (cnt == ZQINIT_CLKS) begin
          next_state = ddr3_fe_pkg::ST_READY;
        end
      end
      ddr3_fe_pkg::ST_READY: begin
        next_cnt = '0;
        if (launch) begin
          next_ba = sel_ba;
          case (op)
            `FE_OP_ACT: begin
              next_code = `FE_CMD_ACT;
              next_a = addr_reg[`FE_ROW_W-1:0];
            end
            `FE_OP_RD, `FE_OP_WR: begin
              next_code = (op == `FE_OP_RD) ? `FE_CMD_RD : `FE_CMD_WR;
              next_a[9:0] = addr_reg[9:0];
              next_a[`FE_AP_BIT] = cmd_ap;
              next_a[`FE_BC_BIT] = ~cmd_chop;
              next_state = ddr3_fe_pkg::ST_BURST;
            end
            `FE_OP_PRE: begin
              next_code = `FE_CMD_PRE;
              next_a[`FE_AP_BIT] = cmd_ap;
            end
            default: begin
              next_code = `FE_CMD_ZQ;
              next_a[`FE_AP_BIT] = (op == `FE_OP_ZQL);
            end
          endcase
        end
      end
      ddr3_fe_pkg::ST_BURST: begin
        if (burst_done) begin
          next_state = ddr3_fe_pkg::ST_READY;
        end
      end
      default: begin
        next_state = ddr3_fe_pkg::ST_CKE_LOW;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ddr3_fe_pkg::ST_CKE_LOW;
      cnt <= '0;
      mrs_idx <= 2'h0;
      BUS.cke <= 1'b0;
      BUS.cs_n <= 1'b1;
      {BUS.ras_n, BUS.cas_n, BUS.we_n} <= `FE_CMD_NOP;
      BUS.ba <= '0;
      BUS.addr <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mrs_idx <= next_idx;
      BUS.cke <= next_cke;
      BUS.cs_n <= next_cs_n;
      {BUS.ras_n, BUS.cas_n, BUS.we_n} <= next_code;
      BUS.ba <= next_ba;
      BUS.addr <= next_a;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BUS.dq_ctl <= '0;
      BUS.dq_ctl_oe <= 1'b0;
      BUS.lower_byte_write_mask <= 2'h0;
      BUS.upper_byte_write_mask <= 2'h0;
    end else begin
      BUS.dq_ctl <= drive ? data[bc[1:0]] : '0;
      BUS.dq_ctl_oe <= drive;
      BUS.lower_byte_write_mask <= drive ?
        {mask_reg[{bc[1:0], 2'h2}], mask_reg[{bc[1:0], 2'h0}]} : 2'h0;
      BUS.upper_byte_write_mask <= drive ?
        {mask_reg[{bc[1:0], 2'h3}], mask_reg[{bc[1:0], 2'h1}]} : 2'h0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bdir <= 1'b0;
      bchop <= 1'b0;
      bap <= 1'b0;
      bbank <= '0;
      shadow <= '0;
    end else if (launch) begin
      bdir <= (op == `FE_OP_WR);
      bchop <= cmd_chop;
      bap <= cmd_ap;
      bbank <= sel_ba;
      if (op == `FE_OP_ACT) begin
        shadow[sel_ba] <= 1'b1;
      end else if (op == `FE_OP_PRE) begin
        shadow <= cmd_ap ? '0 : (shadow & ~(8'h01 << sel_ba));
      end
    end else if (burst_done & bap) begin
      shadow[bbank] <= 1'b0;
    end
  end

  // Burst capture outranks any software write to a data word in the same cycle
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_reg <= '0;
      mask_reg <= '0;
      data <= '{default: '0};
      init_done <= 1'b0;
      refused <= 1'b0;
      RDATA <= '0;
    end else begin
      if (WR & (ADDR == `FE_REG_ADDR)) begin
        addr_reg <= WDATA;
      end
      if (WR & (ADDR == `FE_REG_MASK)) begin
        mask_reg <= WDATA[15:0];
      end
      if (capture) begin
        data[cap_idx] <= BUS.dq;
      end else if (WR & is_data) begin
        data[ADDR[3:2]] <= WDATA;
      end
      if (state == ddr3_fe_pkg::ST_READY) begin
        init_done <= 1'b1;
      end
      if (refuse) begin
        refused <= 1'b1;
      end else if (launch) begin
        refused <= 1'b0;
      end
      RDATA <= RD ? rd_mux : '0;
    end
  end

endmodule : ddr3_fe_controller
`default_nettype wire

// File: testbench/ddr3_fe_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_fe_map.svh"
module ddr3_fe_sva (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`FE_BA_W-1:0] ba,
  input wire logic [`FE_ROW_W-1:0] addr,
  input wire logic dq_ctl_oe,
  input wire logic dq_dev_oe,
  input wire logic ZQ_LONG,
  input wire logic ZQ_SHORT,
  input wire logic CMD_REFUSED,
  input wire logic [`FE_BANKS-1:0] BANK_OPEN
);
  logic cke_q;
  logic [`FE_BA_W-1:0] ba_hold;
  wire [2:0] code = {ras_n, cas_n, we_n};
  // Only commands with clock enable high now and one edge before count
  wire taken = !cs_n && cke && cke_q;
  wire zq_cmd = taken && code == `FE_CMD_ZQ && BANK_OPEN == 8'h00;
  wire act_cmd = taken && code == `FE_CMD_ACT && !BANK_OPEN[ba];
  wire rd_cmd = taken && code == `FE_CMD_RD && BANK_OPEN[ba];
  wire wr_cmd = taken && code == `FE_CMD_WR && BANK_OPEN[ba];
  wire full = addr[`FE_BC_BIT];
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cke_q <= 1'h0;
      ba_hold <= 3'h0;
    end else begin
      cke_q <= cke;
      if (rd_cmd || wr_cmd) begin
        ba_hold <= ba;
      end
    end
  end
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_rd_full;
    !dq_dev_oe ##1 dq_dev_oe [*4] ##1 !dq_dev_oe;
  endsequence
  sequence s_rd_chop;
    !dq_dev_oe ##1 dq_dev_oe [*2] ##1 !dq_dev_oe;
  endsequence
  property p_zq_long;
    zq_cmd && addr[`FE_AP_BIT] |=> ZQ_LONG && !ZQ_SHORT;
  endproperty
  property p_zq_short;
    zq_cmd && !addr[`FE_AP_BIT] |=> ZQ_SHORT && !ZQ_LONG;
  endproperty
  property p_zq_cke;
    ZQ_LONG || ZQ_SHORT |-> $past(cke, 2) && $past(cke);
  endproperty
  property p_act_open;
    act_cmd |=> !CMD_REFUSED &&
      BANK_OPEN == ($past(BANK_OPEN) | (8'h01 << $past(ba)));
  endproperty
  property p_wr_burst;
    wr_cmd && full |=> dq_ctl_oe [*4] ##1 !dq_ctl_oe;
  endproperty
  property p_wr_chop;
    wr_cmd && !full |=> dq_ctl_oe [*2] ##1 !dq_ctl_oe;
  endproperty
  property p_rd_burst;
    rd_cmd && full |=> s_rd_full;
  endproperty
  property p_rd_chop;
    rd_cmd && !full |=> s_rd_chop;
  endproperty
  property p_ap_close;
    rd_cmd && addr[`FE_AP_BIT] |-> ##[3:8] !BANK_OPEN[ba_hold];
  endproperty
  a_zq_long: assert property (p_zq_long)
    else $error("long calibration not reported");
  a_zq_short: assert property (p_zq_short)
    else $error("short calibration not reported");
  a_zq_cke: assert property (p_zq_cke)
    else $error("calibration taken without clock enable");
  a_act_open: assert property (p_act_open)
    else $error("activate did not open only its bank");
  a_wr_burst: assert property (p_wr_burst)
    else $error("write burst not four clocks");
  a_wr_chop: assert property (p_wr_chop)
    else $error("chopped write not two clocks");
  a_rd_burst: assert property (p_rd_burst)
    else $error("read burst not four clocks");
  a_rd_chop: assert property (p_rd_chop)
    else $error("chopped read not two clocks");
  a_ap_close: assert property (p_ap_close)
    else $error("auto precharge left bank open");
endmodule : ddr3_fe_sva
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_fe_map.svh"
module tb;
  typedef struct packed {
    logic [2:0] bank;
    logic [2:0] col;
    logic ilv;
    logic chop;
    logic ap;
    logic [15:0] mask;
  } row_s;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic interleave = 1'h0;
  logic [31:0] rdata;
  logic [31:0] s;
  logic zq_long, zq_short, refused;
  logic [7:0] bank_open;
  logic [15:0] mem [8][8];
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int zq_l = 0, zq_s = 0, mrs_n = 0, gap_bad = 0;
  row_s rows [5] = '{'{3'h0, 3'h0, 1'h0, 1'h0, 1'h1, 16'h0000},
    '{3'h7, 3'h1, 1'h1, 1'h0, 1'h1, 16'h0000},
    '{3'h3, 3'h5, 1'h0, 1'h1, 1'h0, 16'h0000},
    '{3'h3, 3'h6, 1'h1, 1'h1, 1'h1, 16'h8421},
    '{3'h7, 3'h3, 1'h0, 1'h0, 1'h0, 16'hF00F}};
  ddr3_fe_if ddr3_fe_if_i ();
  wire [2:0] code = {ddr3_fe_if_i.ras_n, ddr3_fe_if_i.cas_n,
    ddr3_fe_if_i.we_n};
  ddr3_fe_device ddr3_fe_device_i (.REF_CLK(clk), .RESETN(resetn),
    .BUS(ddr3_fe_if_i.mem), .OTF_ENABLE(1'h1), .FIXED_CHOP(1'h0),
    .INTERLEAVE(interleave), .ZQ_LONG(zq_long), .ZQ_SHORT(zq_short),
    .CMD_REFUSED(refused), .BANK_OPEN(bank_open));
  ddr3_fe_controller #(.CKE_LOW_CLKS(16'h0002),
    .MRD_CLKS(16'h0002)) ddr3_fe_controller_i (
    .REF_CLK(clk), .RESETN(resetn), .BUS(ddr3_fe_if_i.ctl), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  ddr3_fe_sva ddr3_fe_sva_i (.REF_CLK(clk), .RESETN(resetn),
    .cke(ddr3_fe_if_i.cke), .cs_n(ddr3_fe_if_i.cs_n),
    .ras_n(ddr3_fe_if_i.ras_n), .cas_n(ddr3_fe_if_i.cas_n),
    .we_n(ddr3_fe_if_i.we_n), .ba(ddr3_fe_if_i.ba), .addr(ddr3_fe_if_i.addr),
    .dq_ctl_oe(ddr3_fe_if_i.dq_ctl_oe), .dq_dev_oe(ddr3_fe_if_i.dq_dev_oe),
    .ZQ_LONG(zq_long), .ZQ_SHORT(zq_short), .CMD_REFUSED(refused),
    .BANK_OPEN(bank_open));
  always #10 clk = ~clk;
  // Commands between the first mode set and calibration must be idle or further mode sets
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
    if (zq_long) zq_l++;
    if (zq_short) zq_s++;
    if (resetn && !ddr3_fe_if_i.cs_n) begin
      if (code == `FE_CMD_MRS) mrs_n++;
      else if (mrs_n > 0 && zq_l == 0 && code != `FE_CMD_NOP &&
        code != `FE_CMD_ZQ) gap_bad++;
    end
  end
  task automatic check(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 s = rdata;
  endtask : rreg
  task automatic wait_bit(input int b, input logic v);
    for (int n = 0; n < 100; n++) begin
      rreg(`FE_REG_STATUS);
      if (s[b] === v) return;
    end
    check("status wait", 32'h1, 32'h0);
  endtask : wait_bit
  // Bus step of one command, then wait until the controller is idle
  task automatic cmd(input logic [2:0] op, input logic ap, input logic ch,
    input logic [2:0] b, input logic [14:0] a);
    wreg(`FE_REG_ADDR, {13'h0, b, 1'h0, a});
    wreg(`FE_REG_CMD, {27'h0, ch, ap, op});
    wait_bit(`FE_ST_BUSY, 1'h0);
  endtask : cmd
  function automatic logic [2:0] col_at(input logic [2:0] st, b,
    input logic ilv, ch);
    if (ilv) return st ^ b;
    return ch ? {st[2], st[1:0] + b[1:0]} : st + b;
  endfunction : col_at
  task automatic final_report;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    row_s r;
    logic [2:0] c0, c1, ws;
    logic [31:0] d;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    wreg(`FE_REG_CMD, {29'h0, `FE_OP_ACT});
    rreg(`FE_REG_STATUS);
    check("early refused", 32'h1, {31'h0, s[`FE_ST_REFUSED]});
    wait_bit(`FE_ST_INIT, 1'h1);
    check("mode sets", 32'h4, mrs_n);
    check("gap commands", 32'h0, gap_bad);
    check("init long cal", 32'h1, zq_l);
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk);
      interleave <= r.ilv;
      cmd(`FE_OP_ACT, 1'h0, 1'h0, r.bank, 15'h0001);
      check("bank open", 32'h1, {31'h0, bank_open[r.bank]});
      // Chopped rows write the half row that the read covers
      ws = r.chop ? {r.col[2], 2'h0} : 3'h0;
      for (int k = 0; k < 4; k++) begin
        d = {4'hC, 4'(i), 8'(2 * k + 1), 4'hC, 4'(i), 8'(2 * k)};
        wreg(8'(`FE_REG_DATA + 4 * k), d);
        for (int h = 0; h < 2 && !(r.chop && k > 1); h++) begin
          c0 = ws + 3'(2 * k + h);
          if (!r.mask[4 * k + 2 * h]) mem[r.bank][c0][7:0] = d[16 * h+:8];
          if (!r.mask[4 * k + 2 * h + 1])
            mem[r.bank][c0][15:8] = d[16 * h + 8+:8];
        end
      end
      wreg(`FE_REG_MASK, {16'h0, r.mask});
      cmd(`FE_OP_WR, 1'h0, r.chop, r.bank, {12'h0, ws});
      cmd(`FE_OP_RD, r.ap, r.chop, r.bank, {12'h0, r.col});
      for (int k = 0; k < (r.chop ? 2 : 4); k++) begin
        c0 = col_at(r.col, 3'(2 * k), r.ilv, r.chop);
        c1 = col_at(r.col, 3'(2 * k + 1), r.ilv, r.chop);
        rreg(8'(`FE_REG_DATA + 4 * k));
        check("read data", {mem[r.bank][c1], mem[r.bank][c0]}, s);
      end
      if (!r.ap) cmd(`FE_OP_PRE, 1'h0, 1'h0, r.bank, 15'h0000);
      check("banks closed", 32'h0, {24'h0, bank_open});
    end
    cmd(`FE_OP_ZQS, 1'h0, 1'h0, 3'h0, 15'h0000);
    check("short cal", 32'h1, zq_s);
    cmd(`FE_OP_ZQL, 1'h0, 1'h0, 3'h0, 15'h0000);
    check("long cal", 32'h2, zq_l);
    cmd(`FE_OP_ACT, 1'h0, 1'h0, 3'h2, 15'h0002);
    cmd(`FE_OP_ACT, 1'h0, 1'h0, 3'h6, 15'h0004);
    check("two banks", 32'h44, {24'h0, bank_open});
    cmd(`FE_OP_ZQS, 1'h0, 1'h0, 3'h0, 15'h0000);
    rreg(`FE_REG_STATUS);
    check("cal refused", 32'h1, {31'h0, s[`FE_ST_REFUSED]});
    check("no cal", 32'h1, zq_s);
    cmd(`FE_OP_RD, 1'h0, 1'h0, 3'h5, 15'h0000);
    rreg(`FE_REG_STATUS);
    check("closed read", 32'h1, {31'h0, s[`FE_ST_REFUSED]});
    cmd(`FE_OP_PRE, 1'h1, 1'h0, 3'h0, 15'h0000);
    check("all closed", 32'h0, {24'h0, bank_open});
    rreg(8'h40);
    check("unmapped", 32'h0, s);
    cmd(`FE_OP_ACT, 1'h0, 1'h0, 3'h1, 15'h0001);
    @(posedge clk);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    check("reset banks", 32'h0, {24'h0, bank_open});
    resetn <= 1'h1;
    wait_bit(`FE_ST_INIT, 1'h1);
    check("reinit mode sets", 32'h8, mrs_n);
    check("reinit long cal", 32'h3, zq_l);
    final_report();
  end
endmodule : tb
`default_nettype wire
